// ### rtl/aux_ctrl.sv
// Four configurable auxiliary relay outputs with a classic Wishbone slave.
// Sensor values, valve targets, day, slot, tick and alarm come from logic on
// MCLK; the room thermostat lines are pins and are synchronised here.
`timescale 1ns/10ps
`default_nettype none

module aux_ctrl (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic TICK,
    input wire logic [63:0] SENSOR_TEMP,
    input wire logic [39:0] VALVE_TARGET,
    input wire logic [2:0] DAY,
    input wire logic [5:0] SLOT,
    input wire logic ALARM,
    input wire logic [2:0] ROOM_DEMAND,
    input wire logic SERIAL_DEMAND,
    output logic [3:0] AUX_OUT
);

    function automatic logic [7:0] temp_of(input logic [63:0] v,
                                           input logic [2:0] i);
        temp_of = v[{i, 3'b000} +: 8];
    endfunction

    function automatic logic [7:0] sub_sat(input logic [7:0] a,
                                           input logic [7:0] b);
        sub_sat = (a > b) ? a - b : 8'h00;
    endfunction

    function automatic logic [4:0] sidx(input logic [1:0] o,
                                        input logic [2:0] d);
        sidx = 5'({o, 3'b000} - {3'b000, o} + {2'b00, d});
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    // Bus decode
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] cfg_r [0:3];
    logic [31:0] set_r [0:3];
    logic [31:0] lim_r [0:3];
    logic [47:0] sched_r [0:27];
    logic [3:0] err_r;
    logic [3:0] on_r;
    logic [3:0] err_evt;
    logic [4:0] rd_idx_r;
    logic [2:0] room_s1_r;
    logic [2:0] room_s2_r;

    wire req = WB_CYC_I & WB_STB_I & ~ack_r;
    wire wr = req & WB_WE_I;
    wire in_out = (WB_ADR_I[7:6] == 2'b00);
    wire [1:0] a_out = WB_ADR_I[5:4];
    wire [1:0] a_word = WB_ADR_I[3:2];
    wire wr_cfg = wr & in_out & (a_word == aux_pkg::WORD_CFG);
    wire wr_set = wr & in_out & (a_word == aux_pkg::WORD_SET);
    wire wr_lim = wr & in_out & (a_word == aux_pkg::WORD_LIM);
    wire wr_stat = wr & (WB_ADR_I == aux_pkg::ADR_STATUS);
    wire wr_cmd = wr & (WB_ADR_I == aux_pkg::ADR_SCMD);
    wire aux_pkg::aux_scmd_s cmd = WB_DAT_I;
    wire [4:0] cmd_src = sidx(cmd.out, cmd.day);
    wire [47:0] rd_day = sched_r[rd_idx_r];
    wire day_ok = (DAY < 3'(aux_pkg::NUM_DAYS));
    wire slot_ok = (SLOT < 6'(aux_pkg::NUM_SLOTS));
    wire [3:0] relay;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_out) begin
            case (a_word)
                aux_pkg::WORD_CFG: rd_mux = cfg_r[a_out];
                aux_pkg::WORD_SET: rd_mux = set_r[a_out];
                aux_pkg::WORD_LIM: rd_mux = lim_r[a_out];
                default: rd_mux = 32'h0000_0000;
            endcase
        end else begin
            case (WB_ADR_I)
                aux_pkg::ADR_STATUS: rd_mux = {24'h00_0000, err_r, relay};
                aux_pkg::ADR_SLO: rd_mux = rd_day[31:0];
                aux_pkg::ADR_SHI: rd_mux = {16'h0000, rd_day[47:32]};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            dat_r <= rd_mux;
        end
    end

    // Configuration words
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            for (int i = 0; i < aux_pkg::NUM_OUT; i++) begin
                cfg_r[i] <= aux_pkg::CFG_RESET;
                set_r[i] <= aux_pkg::SET_RESET;
                lim_r[i] <= aux_pkg::LIM_RESET;
            end
        end else begin
            if (wr_cfg) cfg_r[a_out] <= merge(cfg_r[a_out], WB_DAT_I, WB_SEL_I);
            if (wr_set) set_r[a_out] <= merge(set_r[a_out], WB_DAT_I, WB_SEL_I);
            if (wr_lim) lim_r[a_out] <= merge(lim_r[a_out], WB_DAT_I, WB_SEL_I);
        end
    end

    // Error flags: write one to clear, a new error wins over the clear
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            err_r <= 4'h0;
        end else begin
            err_r <= (err_r & ~(wr_stat ? WB_DAT_I[7:4] : 4'h0)) | err_evt;
        end
    end

    // Schedule store: set one slot, copy a day, clear a day
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            rd_idx_r <= 5'h00;
            for (int i = 0; i < 28; i++) begin
                sched_r[i] <= 48'h0000_0000_0000;
            end
        end else if (wr_cmd && cmd.day < 3'(aux_pkg::NUM_DAYS)) begin
            rd_idx_r <= cmd_src;
            case (cmd.op)
                aux_pkg::AUX_OP_SET: begin
                    if (cmd.slot < 6'(aux_pkg::NUM_SLOTS))
                        sched_r[cmd_src][cmd.slot] <= cmd.value;
                end
                aux_pkg::AUX_OP_COPY: begin
                    for (int d = 0; d < aux_pkg::NUM_DAYS; d++) begin
                        if (cmd.dest_days[d])
                            sched_r[sidx(cmd.out, 3'(d))] <= sched_r[cmd_src];
                    end
                end
                aux_pkg::AUX_OP_CLEAR: sched_r[cmd_src] <= 48'h0000_0000_0000;
                default: rd_idx_r <= cmd_src;
            endcase
        end
    end

    // Room thermostat pins
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            room_s1_r <= 3'b000;
            room_s2_r <= 3'b000;
        end else begin
            room_s1_r <= ROOM_DEMAND;
            room_s2_r <= room_s1_r;
        end
    end

    wire [3:0] demand = {SERIAL_DEMAND, room_s2_r};

    // One channel per output; only AUX_F_SUPER reads another output's state, via watch_idx
    for (genvar g = 0; g < aux_pkg::NUM_OUT; g++) begin : ch
        wire aux_pkg::aux_cfg_s c = cfg_r[g];
        wire aux_pkg::aux_set_s s = set_r[g];
        wire aux_pkg::aux_lim_s l = lim_r[g];
        wire [7:0] ta = temp_of(SENSOR_TEMP, c.sens_a);
        wire [7:0] tb = temp_of(SENSOR_TEMP, c.sens_b);
        wire [7:0] vt = (c.valve_sel < 3'(aux_pkg::NUM_VALVE)) ?
            VALVE_TARGET[{c.valve_sel, 3'b000} +: 8] : 8'h00;
        wire [47:0] today = sched_r[sidx(2'(g), day_ok ? DAY : 3'h0)];
        wire slot_on = day_ok & slot_ok & today[SLOT];
        wire sched_ok = ~c.sched_en | slot_on;
        wire room_dem = |(demand & c.room_mask);
        wire watched = on_r[c.watch_idx];
        wire up_done = (ta >= s.thr_a) | ~sched_ok;
        wire lo_done = tb >= s.setp_b;

        logic sat_r;
        logic [7:0] tmr_r;
        aux_pkg::aux_sup_e st_r;
        logic on_nxt;
        logic sat_nxt;
        logic [7:0] tmr_nxt;
        aux_pkg::aux_sup_e st_nxt;
        logic evt;

        always_comb begin
            on_nxt = on_r[g];
            sat_nxt = sat_r;
            tmr_nxt = tmr_r;
            st_nxt = st_r;
            evt = 1'b0;
            if (TICK) begin
                case (aux_pkg::aux_func_e'(c.func))
                    aux_pkg::AUX_F_HEAT: begin
                        if (ta >= s.thr_a)
                            on_nxt = 1'b1;
                        else if (ta <= sub_sat(s.thr_a, s.hyst_a))
                            on_nxt = 1'b0;
                    end
                    aux_pkg::AUX_F_HOTW: begin
                        if (tb >= s.setp_b)
                            sat_nxt = 1'b1;
                        else if (tb < sub_sat(s.setp_b, s.hyst_a))
                            sat_nxt = 1'b0;
                        on_nxt = (ta > s.thr_a) & ~sat_nxt
                            & (tb < l.max_t);
                    end
                    aux_pkg::AUX_F_ROOM: on_nxt = room_dem;
                    aux_pkg::AUX_F_WEEK: on_nxt = slot_on;
                    aux_pkg::AUX_F_TANK: begin
                        if (lo_done)
                            on_nxt = 1'b0;
                        else if (ta < s.thr_a)
                            on_nxt = 1'b1;
                    end
                    aux_pkg::AUX_F_HWTANK: begin
                        if (on_r[g]) begin
                            tmr_nxt = !up_done ? aux_pkg::TMR_RESET :
                                (tmr_r < l.delay) ? tmr_r + 8'h01 : tmr_r;
                            if (up_done && lo_done && tmr_r >= l.delay) begin
                                on_nxt = 1'b0;
                                tmr_nxt = aux_pkg::TMR_RESET;
                            end
                        end else if ((sched_ok &&
                                      ta <= sub_sat(s.thr_a, s.hyst_a)) ||
                                     tb <= sub_sat(s.setp_b, s.hyst_b)) begin
                            on_nxt = 1'b1;
                        end
                    end
                    aux_pkg::AUX_F_SUPER: begin
                        case (st_r)
                            aux_pkg::AUX_SUP_WATCH: begin
                                on_nxt = 1'b0;
                                if (sched_ok && watched && ta < s.thr_a) begin
                                    tmr_nxt = tmr_r + 8'h01;
                                    if (tmr_nxt >= l.delay) begin
                                        evt = 1'b1;
                                        on_nxt = 1'b1;
                                        st_nxt = aux_pkg::AUX_SUP_FORCE;
                                        tmr_nxt = aux_pkg::TMR_RESET;
                                    end
                                end else begin
                                    tmr_nxt = aux_pkg::TMR_RESET;
                                end
                            end
                            aux_pkg::AUX_SUP_FORCE: begin
                                on_nxt = 1'b1;
                                if (ta >= s.thr_a) begin
                                    on_nxt = 1'b0;
                                    st_nxt = aux_pkg::AUX_SUP_AFTER;
                                    tmr_nxt = aux_pkg::TMR_RESET;
                                end
                            end
                            aux_pkg::AUX_SUP_AFTER: begin
                                on_nxt = 1'b0;
                                if (!watched || !sched_ok) begin
                                    st_nxt = aux_pkg::AUX_SUP_WATCH;
                                    tmr_nxt = aux_pkg::TMR_RESET;
                                end else if (ta <= sub_sat(s.thr_a, s.hyst_a)) begin
                                    tmr_nxt = tmr_r + 8'h01;
                                    if (tmr_nxt >= l.delay_err) begin
                                        on_nxt = 1'b1;
                                        st_nxt = aux_pkg::AUX_SUP_FORCE;
                                        tmr_nxt = aux_pkg::TMR_RESET;
                                    end
                                end else if (ta >= s.thr_a) begin
                                    tmr_nxt = aux_pkg::TMR_RESET;
                                end
                            end
                            default: st_nxt = aux_pkg::AUX_SUP_WATCH;
                        endcase
                    end
                    aux_pkg::AUX_F_ASSIST: on_nxt = ta < vt;
                    default: on_nxt = 1'b0;
                endcase
            end
        end

        assign err_evt[g] = evt;
        assign relay[g] = (c.func == aux_pkg::AUX_F_OFF) ? 1'b0 :
            ALARM ? c.alarm_on : on_r[g];

        always_ff @(posedge MCLK or posedge RESET) begin
            if (RESET) begin
                on_r[g] <= 1'b0;
                sat_r <= 1'b0;
                tmr_r <= aux_pkg::TMR_RESET;
                st_r <= aux_pkg::AUX_SUP_WATCH;
            end else begin
                on_r[g] <= on_nxt;
                sat_r <= sat_nxt;
                tmr_r <= tmr_nxt;
                st_r <= st_nxt;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            AUX_OUT <= 4'h0;
        end else begin
            AUX_OUT <= relay;
        end
    end

endmodule

`default_nettype wire

// ### include/aux_pkg.sv
// Package for the auxiliary output block: register map, field layouts,
// function codes and reset values.
// Assumes 8-bit unsigned temperatures in whole degrees and tick-based delays.
package aux_pkg;

    localparam int NUM_OUT = 4;
    localparam int NUM_SENS = 8;
    localparam int NUM_VALVE = 5;
    localparam int NUM_DAYS = 7;
    localparam int NUM_SLOTS = 48;

    // Per-output block: byte address = out * OUT_STRIDE + word offset
    localparam logic [7:0] OUT_STRIDE = 8'h10;
    localparam logic [1:0] WORD_CFG = 2'h0;
    localparam logic [1:0] WORD_SET = 2'h1;
    localparam logic [1:0] WORD_LIM = 2'h2;
    localparam logic [7:0] ADR_STATUS = 8'h40;
    localparam logic [7:0] ADR_SCMD = 8'h44;
    localparam logic [7:0] ADR_SLO = 8'h48;
    localparam logic [7:0] ADR_SHI = 8'h4C;

    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] SET_RESET = 32'h0000_0000;
    localparam logic [31:0] LIM_RESET = 32'h0000_0000;
    localparam logic [7:0] TMR_RESET = 8'h00;

    typedef enum logic [3:0] {
        AUX_F_OFF = 4'b0000,
        AUX_F_HEAT = 4'b0001,
        AUX_F_HOTW = 4'b0010,
        AUX_F_ROOM = 4'b0011,
        AUX_F_WEEK = 4'b0100,
        AUX_F_TANK = 4'b0101,
        AUX_F_HWTANK = 4'b0110,
        AUX_F_SUPER = 4'b0111,
        AUX_F_ASSIST = 4'b1000
    } aux_func_e;

    typedef enum logic [1:0] {
        AUX_SUP_WATCH = 2'b00,
        AUX_SUP_FORCE = 2'b01,
        AUX_SUP_AFTER = 2'b10
    } aux_sup_e;

    typedef enum logic [1:0] {
        AUX_OP_NONE = 2'b00,
        AUX_OP_SET = 2'b01,
        AUX_OP_COPY = 2'b10,
        AUX_OP_CLEAR = 2'b11
    } aux_op_e;

    // Function word
    typedef struct packed {
        logic [10:0] spare;
        logic [3:0] room_mask;
        logic [2:0] valve_sel;
        logic [1:0] watch_idx;
        logic [2:0] sens_b;
        logic [2:0] sens_a;
        logic sched_en;
        logic alarm_on;
        logic [3:0] func;
    } aux_cfg_s;

    // Setpoint word
    typedef struct packed {
        logic [7:0] hyst_b;
        logic [7:0] setp_b;
        logic [7:0] hyst_a;
        logic [7:0] thr_a;
    } aux_set_s;

    // Limit and delay word
    typedef struct packed {
        logic [7:0] spare;
        logic [7:0] delay_err;
        logic [7:0] delay;
        logic [7:0] max_t;
    } aux_lim_s;

    // Schedule command word
    typedef struct packed {
        logic [10:0] spare;
        logic [6:0] dest_days;
        logic [1:0] op;
        logic value;
        logic [5:0] slot;
        logic [2:0] day;
        logic [1:0] out;
    } aux_scmd_s;

endpackage

// ### sim/aux_props.sv
// Checker for the auxiliary relay block, bound to its top module.
// Assumes bus writes use all byte lanes; shadows output zero's setup.
`timescale 1ns/10ps
`default_nettype none
module aux_props (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_ACK_O,
    input wire logic TICK,
    input wire logic [63:0] SENSOR_TEMP,
    input wire logic ALARM,
    input wire logic [3:0] AUX_OUT
);
    aux_pkg::aux_cfg_s cfg_r;
    aux_pkg::aux_set_s set_r;
    logic wr_take;
    logic heat;
    logic off;
    logic [7:0] ta;
    logic [7:0] lo;
    assign wr_take = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
    assign heat = cfg_r.func == aux_pkg::AUX_F_HEAT;
    assign off = cfg_r.func == aux_pkg::AUX_F_OFF;
    assign ta = SENSOR_TEMP[8 * cfg_r.sens_a +: 8];
    assign lo = set_r.thr_a > set_r.hyst_a ? set_r.thr_a - set_r.hyst_a
        : 8'h00;
    // Shadow of output zero's function and setpoint words
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            cfg_r <= aux_pkg::CFG_RESET;
            set_r <= aux_pkg::SET_RESET;
        end else if (wr_take && WB_ADR_I[7:2] == 6'h00) begin
            cfg_r <= WB_DAT_I;
        end else if (wr_take && WB_ADR_I[7:2] == 6'h01) begin
            set_r <= WB_DAT_I;
        end
    end
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);
    ack_next_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
        |=> WB_ACK_O) else $error("ack missing after request");
    ack_drop_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I))
        else $error("ack without strobe");
    off_quiet_a: assert property (
        off && $past(off) |-> !AUX_OUT[0])
        else $error("output on while function is off");
    alarm_force_a: assert property (
        (ALARM && !off && $stable(cfg_r)) [*3]
        |-> AUX_OUT[0] == cfg_r.alarm_on)
        else $error("alarm setting not applied");
    heat_on_a: assert property (
        heat && TICK && ta >= set_r.thr_a && !ALARM
        |-> ##2 (AUX_OUT[0] || !heat))
        else $error("heat output not on at threshold");
    heat_off_a: assert property (
        heat && TICK && ta <= lo && !ALARM
        |-> ##2 (!AUX_OUT[0] || !heat))
        else $error("heat output not off at lower level");
    heat_hold_a: assert property (
        heat && $past(heat) && TICK && ta > lo && ta < set_r.thr_a && !ALARM
        |-> ##2 (AUX_OUT[0] == $past(AUX_OUT[0], 2) || !heat))
        else $error("heat output changed inside hysteresis band");
    cover property (heat && $rose(AUX_OUT[0]));
    cover property (heat && $fell(AUX_OUT[0]));
    cover property (ALARM && AUX_OUT[0]);
endmodule
bind aux_ctrl aux_props aux_props_inst (.MCLK(MCLK), .RESET(RESET),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
    .TICK(TICK), .SENSOR_TEMP(SENSOR_TEMP), .ALARM(ALARM),
    .AUX_OUT(AUX_OUT));
`default_nettype wire

// ### sim/aux_plant.sv
// Model of the sensors and room regulators around the relay block.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module aux_plant #(
    parameter int TICK_GAP = 8
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick,
    output logic [63:0] temps,
    output logic [2:0] room,
    output logic serial
);
    int cnt_r;
    // Periodic sample strobe, one cycle wide
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 0;
            tick <= 1'h0;
        end else begin
            cnt_r <= (cnt_r == TICK_GAP - 1) ? 0 : cnt_r + 1;
            tick <= cnt_r == TICK_GAP - 1;
        end
    end
    initial begin
        temps = 64'h0;
        room = 3'h0;
        serial = 1'h0;
    end
    task put(input int s, input logic [7:0] v);
        temps[8 * s +: 8] <= v;
    endtask
    // Three two-level pins and the serial regulator's flag
    task demand(input logic [2:0] r, input logic s);
        room <= r;
        serial <= s;
    endtask
endmodule
`default_nettype wire

// ### sim/test_auxiliary_output_thermostat_logic.sv
// Self-checking bench for the auxiliary relay outputs.
// Assumes the sensor model aux_plant and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module test_auxiliary_output_thermostat_logic;
    logic mclk, reset, cyc, stb, we, ack, tick, alarm, serial;
    logic [7:0] adr;
    logic [31:0] wdat, rdat;
    logic [63:0] temps;
    logic [39:0] valves;
    logic [2:0] day, room;
    logic [5:0] slot;
    logic [3:0] aux;
    int mismatches, cmp_count, cycles;
    aux_ctrl aux_ctrl_inst (.MCLK(mclk), .RESET(reset), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .TICK(tick),
        .SENSOR_TEMP(temps), .VALVE_TARGET(valves), .DAY(day), .SLOT(slot),
        .ALARM(alarm), .ROOM_DEMAND(room), .SERIAL_DEMAND(serial),
        .AUX_OUT(aux));
    aux_plant aux_plant_inst (.clk(mclk), .rst(reset), .tick(tick),
        .temps(temps), .room(room), .serial(serial));
    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d,
             output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge mclk);
        while (ack !== 1'h1) begin
            n++;
            @(posedge mclk);
        end
        q = rdat;
        check({31'h0, ack}, 32'h1);
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge mclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'h1, d, q);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'h0, 32'h0, q);
        check(q, e);
    endtask
    // Wait three sample ticks, then look at one relay
    task expo(input int o, input logic e);
        repeat (24) @(posedge mclk);
        check({31'h0, aux[o]}, {31'h0, e});
    endtask
    task tv(input int s, input logic [7:0] v, input int o, input logic e);
        aux_plant_inst.put(s, v);
        expo(o, e);
    endtask
    function automatic logic [31:0] sc(input logic [2:0] d,
        input logic [5:0] s, input logic [1:0] op, input logic [6:0] dd);
        return {11'h000, dd, op, 1'h1, s, d, 2'h3};
    endfunction
    task t_regs;
        rd(8'h00, aux_pkg::CFG_RESET);
        rd(8'h14, aux_pkg::SET_RESET);
        rd(8'h28, aux_pkg::LIM_RESET);
        rd(aux_pkg::ADR_STATUS, 32'h0000_0000);
        wr(8'h50, 32'hFFFF_FFFF);
        rd(8'h50, 32'h0000_0000);
        wr(8'h30, 32'h0000_0010);
        rd(8'h30, 32'h0000_0010);
    endtask
    task t_heat;
        wr(8'h04, 32'h0000_033C);
        wr(8'h00, 32'h0000_0081);
        tv(2, 8'h3B, 0, 1'h0);
        tv(2, 8'h3C, 0, 1'h1);
        tv(2, 8'h3A, 0, 1'h1);
        tv(2, 8'h39, 0, 1'h0);
    endtask
    task t_hotw;
        wr(8'h18, 32'h0000_0050);
        wr(8'h14, 32'h003C_0328);
        wr(8'h10, 32'h0000_0202);
        aux_plant_inst.put(1, 8'h32);
        tv(0, 8'h1E, 1, 1'h0);
        tv(0, 8'h2D, 1, 1'h1);
        tv(1, 8'h3C, 1, 1'h0);
        tv(1, 8'h3A, 1, 1'h0);
        tv(1, 8'h38, 1, 1'h1);
        wr(8'h18, 32'h0000_0037);
        expo(1, 1'h0);
    endtask
    task t_room;
        wr(8'h20, 32'h0012_0003);
        aux_plant_inst.demand(3'h2, 1'h0);
        expo(2, 1'h0);
        aux_plant_inst.demand(3'h1, 1'h0);
        expo(2, 1'h1);
        aux_plant_inst.demand(3'h0, 1'h1);
        expo(2, 1'h1);
        aux_plant_inst.demand(3'h0, 1'h0);
        expo(2, 1'h0);
    endtask
    task t_alarm;
        wr(8'h00, 32'h0000_0013);
        aux_plant_inst.demand(3'h1, 1'h0);
        expo(2, 1'h1);
        alarm <= 1'h1;
        expo(0, 1'h1);
        check({31'h0, aux[2]}, 32'h0);
        check({31'h0, aux[3]}, 32'h0);
        alarm <= 1'h0;
        expo(0, 1'h0);
    endtask
    task t_week;
        wr(8'h30, 32'h0000_0004);
        day <= 3'h2;
        slot <= 6'h05;
        wr(aux_pkg::ADR_SCMD, sc(3'h2, 6'h05, 2'h1, 7'h00));
        expo(3, 1'h1);
        slot <= 6'h06;
        expo(3, 1'h0);
        wr(aux_pkg::ADR_SCMD, sc(3'h2, 6'h00, 2'h2, 7'h10));
        wr(aux_pkg::ADR_SCMD, sc(3'h2, 6'h00, 2'h3, 7'h00));
        rd(aux_pkg::ADR_SLO, 32'h0000_0000);
        wr(aux_pkg::ADR_SCMD, sc(3'h4, 6'h00, 2'h0, 7'h00));
        rd(aux_pkg::ADR_SLO, 32'h0000_0020);
        day <= 3'h4;
        slot <= 6'h05;
        expo(3, 1'h1);
    endtask
    task t_assist;
        valves <= 40'h00_0032_0000;
        wr(8'h10, 32'h0000_80C8);
        tv(3, 8'h31, 1, 1'h1);
        tv(3, 8'h32, 1, 1'h0);
    endtask
    task t_tank;
        wr(8'h04, 32'h003C_0032);
        wr(8'h00, 32'h0000_0D45);
        expo(0, 1'h1);
        tv(6, 8'h3C, 0, 1'h0);
        aux_plant_inst.put(5, 8'h40);
        tv(6, 8'h10, 0, 1'h0);
        tv(5, 8'h31, 0, 1'h1);
        wr(8'h08, 32'h0000_0300);
        wr(8'h04, 32'h053C_0532);
        wr(8'h00, 32'h0000_0D46);
        aux_plant_inst.put(5, 8'h32);
        tv(6, 8'h3C, 0, 1'h1);
        expo(0, 1'h0);
        tv(5, 8'h2D, 0, 1'h1);
    endtask
    task t_super;
        tv(3, 8'h20, 1, 1'h1);
        wr(8'h28, 32'h0002_0200);
        wr(8'h24, 32'h0000_0528);
        wr(8'h20, 32'h0000_1107);
        expo(2, 1'h1);
        rd(aux_pkg::ADR_STATUS, 32'h0000_004F);
        tv(4, 8'h28, 2, 1'h0);
        tv(4, 8'h23, 2, 1'h1);
        wr(aux_pkg::ADR_STATUS, 32'h0000_0040);
        rd(aux_pkg::ADR_STATUS, 32'h0000_000F);
    endtask
    task t_reset;
        reset <= 1'h1;
        @(posedge mclk);
        reset <= 1'h0;
        @(posedge mclk);
        check({28'h000_0000, aux}, 32'h0000_0000);
        rd(8'h30, aux_pkg::CFG_RESET);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict;
        end
    end
    initial begin
        reset = 1'h1;
        cyc = 1'h0;
        stb = 1'h0;
        we = 1'h0;
        adr = 8'h00;
        wdat = 32'h0;
        valves = 40'h0;
        day = 3'h7;
        slot = 6'h00;
        alarm = 1'h0;
        repeat (20) @(posedge mclk);
        reset <= 1'h0;
        @(posedge mclk);
        t_regs;
        t_heat;
        t_hotw;
        t_room;
        t_alarm;
        t_week;
        t_assist;
        t_tank;
        t_super;
        t_reset;
        give_verdict;
    end
endmodule
`default_nettype wire
